// File: design/eaio_pkg.sv
// shared constants for the extended address and io capability register bank
`default_nettype none
package eaio_pkg;
   localparam int unsigned REG_W      = 16;
   localparam int unsigned NUM_W      = 8;
   localparam int unsigned HI_W       = 6;
   localparam int unsigned XADDR_W    = 22;
   localparam int unsigned SPACE_W    = 3;
   localparam int unsigned PEND_W     = 8;
   localparam int unsigned IRQ_W      = 3;
   localparam int unsigned SETS       = 2;
   localparam int unsigned RST_SYNC_W = 2;

   localparam logic [NUM_W-1:0] REG_AUTO_CFG = 8'h09;
   localparam logic [NUM_W-1:0] REG_AUTO_LOW = 8'h0a;
   localparam logic [NUM_W-1:0] REG_AUTO_ACC = 8'h0b;
   localparam logic [NUM_W-1:0] REG_IO_CAP   = 8'h0d;
   localparam logic [NUM_W-1:0] REG_BULK_CFG = 8'h0e;
   localparam logic [NUM_W-1:0] REG_BULK_LOW = 8'h0f;
   localparam logic [NUM_W-1:0] REG_BULK_ACC = 8'h10;
   localparam logic [NUM_W-1:0] REG_IRQ_STAT = 8'h20;
   localparam logic [NUM_W-1:0] REG_IRQ_MASK = 8'h21;

   localparam logic [REG_W-1:0]  CFG_RESET  = 16'h0000;
   localparam logic [REG_W-1:0]  LOW_RESET  = 16'h0000;
   localparam logic [REG_W-1:0]  CAP_RESET  = 16'h0000;
   localparam logic [REG_W-1:0]  DATA_ZERO  = 16'h0000;
   localparam logic [PEND_W-1:0] PEND_LOW   = 8'h00;
   localparam logic [IRQ_W-1:0]  IRQ_RESET  = 3'h0;

   localparam int unsigned RD_STEP_LSB = 14;
   localparam int unsigned WR_STEP_LSB = 12;
   localparam int unsigned SPACE_LSB   = 9;
   localparam int unsigned STEP_LSB    = 7;
   localparam int unsigned HI_LSB      = 0;
   localparam int unsigned MODE_W      = 2;
   localparam int unsigned STEP_W      = 2;

   localparam int unsigned IRQ_XERR   = 0;
   localparam int unsigned IRQ_SWITCH = 1;
   localparam int unsigned IRQ_AUTO   = 2;

   typedef enum logic [1:0] {
      EAIO_HOLD  = 2'h0,
      EAIO_INC   = 2'h1,
      EAIO_DEC   = 2'h2,
      EAIO_UNDEF = 2'h3
   } eaio_step_e;

   typedef enum logic [1:0] {
      EAIO_ST_OK   = 2'h0,
      EAIO_ST_XERR = 2'h1,
      EAIO_ST_PEND = 2'h3
   } eaio_status_e;

   typedef enum logic [3:0] {
      EAIO_ERR_NONE = 4'h0,
      EAIO_ERR_RNW  = 4'h1,
      EAIO_ERR_CIP  = 4'h3,
      EAIO_ERR_CII  = 4'h4,
      EAIO_ERR_CIE  = 4'h6,
      EAIO_ERR_ERE  = 4'h7,
      EAIO_ERR_ERO  = 4'h8
   } eaio_err_e;
endpackage
`default_nettype wire

// File: design/eaio_ext_set.sv
// one extended address set: configuration, low address and pointer stepping
`default_nettype none
module eaio_ext_set
#(
   parameter int unsigned ADDR_W = eaio_pkg::XADDR_W
)
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      load,
   input  wire logic [eaio_pkg::REG_W-1:0] load_cfg,
   input  wire logic [eaio_pkg::REG_W-1:0] load_low,
   input  wire logic                      cfg_wr,
   input  wire logic                      low_wr,
   input  wire logic [eaio_pkg::REG_W-1:0] wdata,
   input  wire logic                      step_rd,
   input  wire logic                      step_wr,
   output logic      [eaio_pkg::REG_W-1:0] cfg_q,
   output logic      [eaio_pkg::REG_W-1:0] low_q
);
   import eaio_pkg::*;

   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] ptr_d;
   logic [STEP_W-1:0] delta;
   eaio_step_e        mode;

   if (ADDR_W != HI_W + REG_W)
   begin : g_bad_width
      $error("pointer width must be high bits plus low register");
   end

   // pointer is high bits then low word
   assign ptr   = {cfg_q[HI_LSB +: HI_W], low_q};
   assign delta = cfg_q[STEP_LSB +: STEP_W];
   assign mode  = eaio_step_e'(step_rd ? cfg_q[RD_STEP_LSB +: MODE_W] : cfg_q[WR_STEP_LSB +: MODE_W]);

   always_comb
   begin
      ptr_d = ptr;
      if (step_rd || step_wr)
      begin
         unique case (mode)
            EAIO_INC:               ptr_d = ptr + ADDR_W'(delta);
            EAIO_DEC:               ptr_d = ptr - ADDR_W'(delta);
            EAIO_HOLD, EAIO_UNDEF:  ptr_d = ptr;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= CFG_RESET;
         low_q <= LOW_RESET;
      end
      else if (load)
      begin
         cfg_q <= load_cfg;
         low_q <= load_low;
      end
      else if (cfg_wr)
      begin
         cfg_q <= wdata;
      end
      else if (low_wr)
      begin
         low_q <= wdata;
      end
      else
      begin
         cfg_q[HI_LSB +: HI_W] <= ptr_d[REG_W +: HI_W];
         low_q                 <= ptr_d[REG_W-1:0];
      end
   end

   chk_step_auto_step_size:
   assert property (@(posedge clk) disable iff (!rst_n)
      (step_rd || step_wr) && !load && !cfg_wr && !low_wr && mode == EAIO_INC
      |=> {cfg_q[HI_LSB +: HI_W], low_q} == $past(ptr) + ADDR_W'($past(delta)))
   else $error("pointer did not advance by the step size");
endmodule
`default_nettype wire

// File: design/eaio_cap_apply.sv
// applies a new link setting only once the response has left
`default_nettype none
module eaio_cap_apply
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      nv_load,
   input  wire logic [eaio_pkg::REG_W-1:0] nv_val,
   input  wire logic                      cap_wr,
   input  wire logic [eaio_pkg::REG_W-1:0] cap_val,
   input  wire logic                      rsp_sent,
   output logic      [eaio_pkg::REG_W-1:0] link_cap_q,
   output logic                           switching_q,
   output logic                           switched_q
);
   import eaio_pkg::*;

   logic [REG_W-1:0] pend_val_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_cap_q  <= CAP_RESET;
         pend_val_q  <= CAP_RESET;
         switching_q <= 1'b0;
         switched_q  <= 1'b0;
      end
      else
      begin
         switched_q <= 1'b0;
         if (nv_load)
         begin
            link_cap_q <= nv_val;
         end
         if (cap_wr)
         begin
            switching_q <= 1'b1;
            pend_val_q  <= cap_val;
         end
         else if (rsp_sent && switching_q)
         begin
            link_cap_q  <= pend_val_q;
            switching_q <= 1'b0;
            switched_q  <= 1'b1;
         end
      end
   end

   chk_cap_late:
   assert property (@(posedge clk) disable iff (!rst_n)
      switching_q && !rsp_sent && !nv_load |=> $stable(link_cap_q) && switching_q)
   else $error("link setting changed before the response was sent");
endmodule
`default_nettype wire

// File: design/eaio_regs.sv
// register bank for io capability and the two extended address sets
`default_nettype none
module eaio_regs
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [eaio_pkg::NUM_W-1:0]    reg_addr,
   input  wire logic [eaio_pkg::REG_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic                               rsp_valid_q,
   output logic      [eaio_pkg::REG_W-1:0]    rsp_data_q,
   output var eaio_pkg::eaio_status_e         rsp_status_q,
   output var eaio_pkg::eaio_err_e            rsp_error_q,
   input  wire logic                          rsp_sent,
   input  wire logic [eaio_pkg::REG_W-1:0]    cap_nv_default,
   output logic                               cap_nv_wr_q,
   output logic      [eaio_pkg::REG_W-1:0]    cap_nv_data_q,
   output logic      [eaio_pkg::REG_W-1:0]    link_cap_q,
   output logic                               link_switching_q,
   input  wire logic                          auto_load,
   input  wire logic [eaio_pkg::REG_W-1:0]    auto_load_cfg,
   input  wire logic [eaio_pkg::REG_W-1:0]    auto_load_low,
   output logic      [eaio_pkg::REG_W-1:0]    auto_cfg_q,
   output logic      [eaio_pkg::REG_W-1:0]    auto_low_q,
   input  wire logic [eaio_pkg::REG_W-1:0]    auto_rd_data,
   input  wire logic                          auto_rd_err,
   input  wire logic                          auto_wr_err,
   input  wire logic                          auto_wr_busy,
   output logic      [eaio_pkg::REG_W-1:0]    bulk_cfg_q,
   output logic      [eaio_pkg::REG_W-1:0]    bulk_low_q,
   input  wire logic [eaio_pkg::REG_W-1:0]    bulk_rd_data,
   input  wire logic                          bulk_rd_err,
   input  wire logic                          bulk_wr_err,
   input  wire logic                          bulk_wr_busy,
   output logic      [eaio_pkg::SETS-1:0]     tgt_wr_q,
   output logic      [eaio_pkg::XADDR_W-1:0]  tgt_wr_addr_q,
   output logic      [eaio_pkg::SPACE_W-1:0]  tgt_wr_space_q,
   output logic      [eaio_pkg::REG_W-1:0]    tgt_wr_data_q,
   output logic                               irq_q
);
   import eaio_pkg::*;

   logic [RST_SYNC_W-1:0] rst_q;
   logic                  rst_n_q;
   logic                  loaded_q;
   logic                  nv_load;
   logic [REG_W-1:0]      cap_q;
   logic [PEND_W-1:0]     pend_id_q;
   logic [IRQ_W-1:0]      stat_q;
   logic [IRQ_W-1:0]      stat_set;
   logic [IRQ_W-1:0]      mask_q;
   logic                  switched;
   logic                  cmd;
   logic                  sel;
   logic                  xerr;
   logic                  pend;
   logic                  cap_wr;
   logic                  mask_wr;
   logic                  stat_rd;
   logic [SETS-1:0]       cfg_wr;
   logic [SETS-1:0]       low_wr;
   logic [SETS-1:0]       step_rd;
   logic [SETS-1:0]       step_wr;
   logic [SETS-1:0]       load;
   logic [SETS-1:0]       rd_err;
   logic [SETS-1:0]       wr_err;
   logic [SETS-1:0]       wr_busy;
   logic [REG_W-1:0]      rd_data  [SETS];
   logic [REG_W-1:0]      load_cfg [SETS];
   logic [REG_W-1:0]      load_low [SETS];
   logic [REG_W-1:0]      cfg_q    [SETS];
   logic [REG_W-1:0]      low_q    [SETS];
   logic [REG_W-1:0]      data_d;
   eaio_status_e          status_d;
   eaio_err_e             err_d;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_q <= '0;
      end
      else
      begin
         rst_q <= {rst_q[RST_SYNC_W-2:0], 1'b1};
      end
   end
   assign rst_n_q = rst_q[RST_SYNC_W-1];

   assign load     = {1'b0, auto_load};
   assign load_cfg = '{auto_load_cfg, CFG_RESET};
   assign load_low = '{auto_load_low, LOW_RESET};
   assign rd_data  = '{auto_rd_data, bulk_rd_data};
   assign rd_err   = {bulk_rd_err, auto_rd_err};
   assign wr_err   = {bulk_wr_err, auto_wr_err};
   assign wr_busy  = {bulk_wr_busy, auto_wr_busy};
   assign auto_cfg_q = cfg_q[0];
   assign auto_low_q = low_q[0];
   assign bulk_cfg_q = cfg_q[1];
   assign bulk_low_q = low_q[1];

   for (genvar g = 0; g < SETS; g++)
   begin : g_set
      eaio_ext_set u_set
      (
         .clk      (clk),
         .rst_n    (rst_n_q),
         .load     (load[g]),
         .load_cfg (load_cfg[g]),
         .load_low (load_low[g]),
         .cfg_wr   (cfg_wr[g]),
         .low_wr   (low_wr[g]),
         .wdata    (reg_wdata),
         .step_rd  (step_rd[g]),
         .step_wr  (step_wr[g]),
         .cfg_q    (cfg_q[g]),
         .low_q    (low_q[g])
      );
   end

   assign cmd = reg_wr || reg_rd;
   assign sel = (reg_addr == REG_BULK_CFG) || (reg_addr == REG_BULK_LOW) || (reg_addr == REG_BULK_ACC);
   assign nv_load = !loaded_q;

   // command decode and response
   always_comb
   begin
      data_d   = DATA_ZERO;
      status_d = EAIO_ST_OK;
      err_d    = EAIO_ERR_NONE;
      cfg_wr   = '0;
      low_wr   = '0;
      step_rd  = '0;
      step_wr  = '0;
      cap_wr   = 1'b0;
      mask_wr  = 1'b0;
      stat_rd  = 1'b0;
      pend     = 1'b0;
      case (reg_addr)
         REG_AUTO_CFG, REG_BULK_CFG:
         begin
            if (reg_rd)
            begin
               data_d = cfg_q[sel];
            end
            else if (reg_wr)
            begin
               cfg_wr[sel] = 1'b1;
               data_d      = reg_wdata;
            end
         end
         REG_AUTO_LOW, REG_BULK_LOW:
         begin
            if (reg_rd)
            begin
               data_d = low_q[sel];
            end
            else if (reg_wr && sel)
            begin
               low_wr[sel] = 1'b1;
               data_d      = reg_wdata;
            end
            else if (reg_wr)
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_RNW;
            end
         end
         REG_AUTO_ACC, REG_BULK_ACC:
         begin
            if (reg_rd && rd_err[sel])
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_ERE;
            end
            else if (reg_rd)
            begin
               data_d       = rd_data[sel];
               step_rd[sel] = 1'b1;
            end
            else if (reg_wr && wr_err[sel])
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_ERO;
            end
            else if (reg_wr)
            begin
               step_wr[sel] = 1'b1;
               if (wr_busy[sel])
               begin
                  pend     = 1'b1;
                  status_d = EAIO_ST_PEND;
                  data_d   = {pend_id_q, PEND_LOW};
               end
            end
         end
         REG_IO_CAP:
         begin
            if (cmd && !loaded_q)
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_CII;
            end
            else if (cmd && link_switching_q)
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_CIP;
            end
            else if (reg_rd)
            begin
               data_d = cap_q;
            end
            else if (reg_wr)
            begin
               cap_wr = 1'b1;
               data_d = reg_wdata;
            end
         end
         REG_IRQ_STAT:
         begin
            if (reg_rd)
            begin
               data_d  = REG_W'(stat_q);
               stat_rd = 1'b1;
            end
            else if (reg_wr)
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_RNW;
            end
         end
         REG_IRQ_MASK:
         begin
            if (reg_rd)
            begin
               data_d = REG_W'(mask_q);
            end
            else if (reg_wr)
            begin
               mask_wr = 1'b1;
               data_d  = reg_wdata;
            end
         end
         default:
         begin
            if (cmd)
            begin
               status_d = EAIO_ST_XERR;
               err_d    = EAIO_ERR_CIE;
            end
         end
      endcase
   end

   assign xerr = cmd && (status_d == EAIO_ST_XERR);

   // response one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         rsp_valid_q  <= 1'b0;
         rsp_data_q   <= DATA_ZERO;
         rsp_status_q <= EAIO_ST_OK;
         rsp_error_q  <= EAIO_ERR_NONE;
      end
      else
      begin
         rsp_valid_q  <= cmd;
         rsp_data_q   <= data_d;
         rsp_status_q <= status_d;
         rsp_error_q  <= err_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         loaded_q <= 1'b0;
         cap_q    <= CAP_RESET;
      end
      else if (!loaded_q)
      begin
         loaded_q <= 1'b1;
         cap_q    <= cap_nv_default;
      end
      else if (cap_wr)
      begin
         cap_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cap_nv_wr_q   <= 1'b0;
         cap_nv_data_q <= CAP_RESET;
      end
      else
      begin
         cap_nv_wr_q <= cap_wr;
         if (cap_wr)
         begin
            cap_nv_data_q <= reg_wdata;
         end
      end
   end

   eaio_cap_apply u_cap
   (
      .clk         (clk),
      .rst_n       (rst_n_q),
      .nv_load     (nv_load),
      .nv_val      (cap_nv_default),
      .cap_wr      (cap_wr),
      .cap_val     (reg_wdata),
      .rsp_sent    (rsp_sent),
      .link_cap_q  (link_cap_q),
      .switching_q (link_switching_q),
      .switched_q  (switched)
   );

   // target write strobe and pending id
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         tgt_wr_q       <= '0;
         tgt_wr_addr_q  <= '0;
         tgt_wr_space_q <= '0;
         tgt_wr_data_q  <= DATA_ZERO;
         pend_id_q      <= '0;
      end
      else
      begin
         tgt_wr_q <= step_wr;
         if (|step_wr)
         begin
            tgt_wr_addr_q  <= {cfg_q[sel][HI_LSB +: HI_W], low_q[sel]};
            tgt_wr_space_q <= cfg_q[sel][SPACE_LSB +: SPACE_W];
            tgt_wr_data_q  <= reg_wdata;
         end
         if (pend)
         begin
            pend_id_q <= pend_id_q + PEND_W'(1);
         end
      end
   end

   // sticky status, read clears, set wins
   assign stat_set = {auto_load, switched, xerr};
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         stat_q <= IRQ_RESET;
         mask_q <= IRQ_RESET;
         irq_q  <= 1'b0;
      end
      else
      begin
         stat_q <= (stat_rd ? IRQ_RESET : stat_q) | stat_set;
         if (mask_wr)
         begin
            mask_q <= reg_wdata[IRQ_W-1:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_q);

   chk_cap_echo:
   assert property (reg_wr && reg_addr == REG_IO_CAP && loaded_q && !link_switching_q
      |=> rsp_status_q == EAIO_ST_OK && rsp_data_q == $past(reg_wdata) && link_switching_q)
   else $error("capability write not echoed with ok");

   chk_cap_rd_err:
   assert property (reg_rd && reg_addr == REG_IO_CAP && link_switching_q
      |=> rsp_status_q == EAIO_ST_XERR && rsp_data_q == DATA_ZERO && rsp_error_q == EAIO_ERR_CIP)
   else $error("failed capability read not reported");

   chk_cap_no_pend:
   assert property (cmd && reg_addr == REG_IO_CAP |=> rsp_valid_q && rsp_status_q != EAIO_ST_PEND)
   else $error("capability access reported pending");

   chk_rd_no_pend:
   assert property (reg_rd |=> rsp_status_q != EAIO_ST_PEND)
   else $error("read reported pending");

   chk_err_hold:
   assert property (reg_rd && reg_addr == REG_AUTO_ACC && auto_rd_err && !auto_load
      |=> $stable(cfg_q[0]) && $stable(low_q[0]) && rsp_status_q == EAIO_ST_XERR)
   else $error("pointer moved on failed read");

   chk_sets_apart:
   assert property (auto_load && !cmd |=> $stable(cfg_q[1]) && $stable(low_q[1]))
   else $error("automatic load disturbed the bulk set");

   chk_auto_load:
   assert property (auto_load |=> cfg_q[0] == $past(auto_load_cfg) && low_q[0] == $past(auto_load_low))
   else $error("automatic set not loaded");

   chk_cap_reset:
   assert property ($rose(loaded_q) |-> cap_q == $past(cap_nv_default) && link_cap_q == $past(cap_nv_default))
   else $error("capability default not restored");

   chk_low_locked:
   assert property (reg_wr && reg_addr == REG_AUTO_LOW && !auto_load
      |=> rsp_error_q == EAIO_ERR_RNW && $stable(low_q[0]))
   else $error("automatic low address accepted a write");

   cov_cap_switch: cover property (link_switching_q ##1 rsp_sent ##1 !link_switching_q);
   cov_wr_pend: cover property (rsp_status_q == EAIO_ST_PEND);
   cov_rd_err: cover property (rsp_error_q == EAIO_ERR_ERE);
   cov_auto_read: cover property (auto_load ##1 reg_rd && reg_addr == REG_AUTO_ACC);
endmodule
`default_nettype wire

// File: sim/eaio_far_model.sv
// far side model: target memory and link sender
`default_nettype none
module eaio_far_model
(
   input  wire logic        clk,
   input  wire logic [15:0] low_a,
   input  wire logic [15:0] low_b,
   input  wire logic        switching,
   output logic      [15:0] data_a,
   output logic      [15:0] data_b,
   output logic      [1:0]  err,
   output logic      [1:0]  busy,
   output logic             sent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_q;
   // target data follows the pointer, top half fails
   assign data_a = ~low_a;
   assign data_b = ~low_b;
   assign err    = {low_b[15], low_a[15]};
   assign busy   = {low_b[14], low_a[14]};
   always_ff @(posedge clk)
   begin
      cnt_q <= switching ? cnt_q + 3'h1 : 3'h0;
   end
   assign sent = (cnt_q == 3'h7);
endmodule
`default_nettype wire

// File: sim/ext_addr_io_config_regs_tb_top.sv
// self-checking bench for the register bank
`default_nettype none
module ext_addr_io_config_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import eaio_pkg::*;
   localparam logic [15:0] NV = 16'h1234;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ld = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wd = 16'h0000, ldc = 16'h0000, ldl = 16'h0000;
   logic vld, nvw, sw, irq, sent;
   logic [15:0] rdat, nvd, lcap, acfg, alow, bcfg, blow, da, db, twd;
   eaio_status_e st;
   eaio_err_e er;
   logic [1:0] tw, err, busy;
   logic [21:0] twa;
   logic [2:0] tws;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   eaio_regs dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .rsp_valid_q(vld), .rsp_data_q(rdat), .rsp_status_q(st), .rsp_error_q(er), .rsp_sent(sent),
      .cap_nv_default(NV), .cap_nv_wr_q(nvw), .cap_nv_data_q(nvd), .link_cap_q(lcap),
      .link_switching_q(sw), .auto_load(ld), .auto_load_cfg(ldc), .auto_load_low(ldl),
      .auto_cfg_q(acfg), .auto_low_q(alow), .auto_rd_data(da), .auto_rd_err(err[0]),
      .auto_wr_err(err[0]), .auto_wr_busy(busy[0]), .bulk_cfg_q(bcfg), .bulk_low_q(blow),
      .bulk_rd_data(db), .bulk_rd_err(err[1]), .bulk_wr_err(err[1]), .bulk_wr_busy(busy[1]),
      .tgt_wr_q(tw), .tgt_wr_addr_q(twa), .tgt_wr_space_q(tws), .tgt_wr_data_q(twd), .irq_q(irq));
   eaio_far_model far (.clk(clk), .low_a(alow), .low_b(blow), .switching(sw), .data_a(da), .data_b(db),
      .err(err), .busy(busy), .sent(sent));
   initial forever #5 clk = ~clk;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e,
                      input logic [1:0] s, input logic [3:0] c);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("valid", 22'h1, vld);
      chk("status", s, st);
      chk("error", c, er);
      if (!w || a == REG_IO_CAP || a == REG_BULK_ACC)
         chk("data", e, rdat);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         finish_test();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      acc(0, REG_IO_CAP, 0, NV, 0, 0);
      acc(0, REG_BULK_CFG, 0, 0, 0, 0);
      acc(1, REG_IO_CAP, 16'h0055, 16'h0055, 0, 0);
      chk("nv_wr", 22'h1, nvw);
      chk("nv_data", 16'h0055, nvd);
      chk("link_old", NV, lcap);
      acc(0, REG_IO_CAP, 0, 0, 1, 3);
      repeat (20) @(posedge clk);
      chk("link_new", 16'h0055, lcap);
      acc(0, REG_IO_CAP, 0, 16'h0055, 0, 0);
      acc(1, REG_BULK_CFG, 16'h6483, 0, 0, 0);
      acc(1, REG_BULK_LOW, 16'h0010, 0, 0, 0);
      acc(0, REG_BULK_ACC, 0, 16'hffef, 0, 0);
      chk("low_inc", 16'h0011, blow);
      acc(1, REG_BULK_ACC, 16'h00aa, 0, 0, 0);
      chk("tgt_wr", 22'h2, tw);
      chk("tgt_addr", 22'h030011, twa);
      chk("tgt_space", 22'h2, tws);
      chk("tgt_data", 16'h00aa, twd);
      chk("low_dec", 16'h0010, blow);
      acc(1, REG_BULK_LOW, 16'h4000, 0, 0, 0);
      acc(1, REG_BULK_ACC, 16'h0001, 16'h0000, 3, 0);
      chk("pend_step", 16'h3fff, blow);
      acc(1, REG_BULK_LOW, 16'h4000, 0, 0, 0);
      acc(1, REG_BULK_ACC, 16'h0002, 16'h0100, 3, 0);
      @(posedge clk);
      ld <= 1'b1;
      ldc <= 16'h5111;
      ldl <= 16'h8022;
      @(posedge clk);
      ld <= 1'b0;
      #1;
      chk("auto_cfg", 16'h5111, acfg);
      chk("auto_low", 16'h8022, alow);
      chk("bulk_cfg", 16'h6483, bcfg);
      acc(0, REG_AUTO_ACC, 0, 0, 1, EAIO_ERR_ERE);
      chk("auto_kept", 16'h8022, alow);
      acc(1, REG_AUTO_LOW, 16'h0005, 0, 1, EAIO_ERR_RNW);
      acc(1, REG_BULK_LOW, 16'h8000, 0, 0, 0);
      acc(0, REG_BULK_ACC, 0, 0, 1, EAIO_ERR_ERE);
      chk("low_kept", 16'h8000, blow);
      acc(1, REG_BULK_ACC, 16'h0001, 0, 1, EAIO_ERR_ERO);
      chk("tgt_none", 22'h0, tw);
      chk("low_kept_wr", 16'h8000, blow);
      acc(1, REG_IRQ_MASK, 16'h0001, 0, 0, 0);
      acc(1, 8'h30, 0, 0, 1, EAIO_ERR_CIE);
      @(posedge clk);
      #1;
      chk("irq_set", 22'h1, irq);
      acc(0, REG_IRQ_STAT, 0, 16'h0007, 0, 0);
      @(posedge clk);
      #1;
      chk("irq_clr", 22'h0, irq);
      acc(1, REG_IRQ_MASK, 16'h0000, 0, 0, 0);
      acc(1, 8'h30, 0, 0, 1, EAIO_ERR_CIE);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_mask", 22'h0, irq);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("link_rst", NV, lcap);
      acc(0, REG_IO_CAP, 0, NV, 0, 0);
      finish_test();
   end
endmodule
`default_nettype wire
